// file: lerm_pkg.sv
// ==========================================================
// link error rate monitor constants and types
package lerm_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [15:0] CTRL_OFS = 16'h1068;
  localparam logic [15:0] LIMITS_OFS = 16'h106C;
  localparam logic [15:0] IRQ_STS_OFS = 16'h1070;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h1074;

  // ==========================================================
  // field positions (lsb)
  localparam int DECAY_SEL_LSB = 24;
  localparam int OVERSHOOT_LSB = 16;
  localparam int PEAK_LSB = 8;
  localparam int TALLY_LSB = 0;
  localparam int BROKEN_LIM_LSB = 24;
  localparam int DEGRADED_LIM_LSB = 16;
  localparam int IRQ_BROKEN_BIT = 0;
  localparam int IRQ_DEGRADED_BIT = 1;

  // ==========================================================
  // register layouts
  typedef struct packed {
    logic [7:0] decay_step_select;
    logic [5:0] rsvd;
    logic [1:0] overshoot_limit_select;
    logic [7:0] peak_tally;
    logic [7:0] link_fault_tally;
  } lerm_ctrl_t;

  typedef struct packed {
    logic [7:0] broken_link_limit;
    logic [7:0] degraded_link_limit;
    logic [15:0] rsvd;
  } lerm_limits_t;

  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h8000_0000;
  localparam logic [31:0] LIMITS_RST = 32'hFFFF_0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ==========================================================
  // decay step codes
  localparam logic [7:0] DECAY_OFF = 8'h00;
  localparam logic [7:0] DECAY_C01 = 8'h01;
  localparam logic [7:0] DECAY_C02 = 8'h02;
  localparam logic [7:0] DECAY_C04 = 8'h04;
  localparam logic [7:0] DECAY_C08 = 8'h08;
  localparam logic [7:0] DECAY_C10 = 8'h10;
  localparam logic [7:0] DECAY_C20 = 8'h20;
  localparam logic [7:0] DECAY_C40 = 8'h40;
  localparam logic [7:0] DECAY_C80 = 8'h80;
  localparam logic [7:0] DECAY_DEBUG = 8'hFF;

  // ==========================================================
  // overshoot allowances above the broken link limit
  localparam logic [8:0] OVERSHOOT_00 = 9'h002;
  localparam logic [8:0] OVERSHOOT_01 = 9'h004;
  localparam logic [8:0] OVERSHOOT_10 = 9'h010;
  localparam logic [8:0] TALLY_MAX = 9'h0FF;

  // ==========================================================
  // decay periods and cycle counts
  localparam real CLK_MHZ = 50.0;
  localparam real DECAY_01_MS = 1.31;
  localparam real DECAY_02_MS = 10.48;
  localparam real DECAY_04_MS = 83.88;
  localparam real DECAY_08_S = 1.342;
  localparam real DECAY_10_S = 10.74;
  localparam real DECAY_20_S = 86.0;
  localparam real DECAY_40_S = 1374.0;
  localparam real DECAY_80_S = 10995.0;
  localparam real DECAY_DEBUG_US = 1.28;
  localparam int CYC_W = 40;
  localparam longint DECAY_01_CYC = longint'(DECAY_01_MS * 1.0e3 * CLK_MHZ);
  localparam longint DECAY_02_CYC = longint'(DECAY_02_MS * 1.0e3 * CLK_MHZ);
  localparam longint DECAY_04_CYC = longint'(DECAY_04_MS * 1.0e3 * CLK_MHZ);
  localparam longint DECAY_08_CYC = longint'(DECAY_08_S * 1.0e6 * CLK_MHZ);
  localparam longint DECAY_10_CYC = longint'(DECAY_10_S * 1.0e6 * CLK_MHZ);
  localparam longint DECAY_20_CYC = longint'(DECAY_20_S * 1.0e6 * CLK_MHZ);
  localparam longint DECAY_40_CYC = longint'(DECAY_40_S * 1.0e6 * CLK_MHZ);
  localparam longint DECAY_80_CYC = longint'(DECAY_80_S * 1.0e6 * CLK_MHZ);
  localparam logic [CYC_W-1:0] DECAY_DEBUG_CYC =
    CYC_W'(longint'(DECAY_DEBUG_US * CLK_MHZ));

  // ==========================================================
  // data phase states
  typedef enum logic [1:0] {
    DP_IDLE,
    DP_WR,
    DP_RD_WAIT,
    DP_RD_DONE
  } lerm_dphase_t;

endpackage

// file: lerm_monitor.sv
// Functional notes
// - keep 8-bit error tally, plus one per detected error
// - tally saturates, never wraps up or below zero
// - tally keeps counting after any limit is reached
// - decay select zero means the tally never decays
// - one-hot decay codes decrement once per selected period; others except all ones none
// - decay periods are times, converted from the bus clock rate
// - decay select all ones decrements every 1.28 us, debug only
// - overshoot select caps tally above broken limit: 2, 4, 16, none
// - peak follows the tally whenever the tally rises above it
// - peak only falls through a software write
// - report when the tally becomes equal to a limit
// - broken limit zero disables it; 1 to 255 sets report count
// - degraded limit zero disables it; 1 to 255 sets report count
// - broken limit report marks a possibly broken link
// - degraded limit report marks a degrading link, separately
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module lerm_monitor #(
  parameter logic [39:0] DECAY_01_CYC = 40'(lerm_pkg::DECAY_01_CYC),
  parameter logic [39:0] DECAY_02_CYC = 40'(lerm_pkg::DECAY_02_CYC),
  parameter logic [39:0] DECAY_04_CYC = 40'(lerm_pkg::DECAY_04_CYC),
  parameter logic [39:0] DECAY_08_CYC = 40'(lerm_pkg::DECAY_08_CYC),
  parameter logic [39:0] DECAY_10_CYC = 40'(lerm_pkg::DECAY_10_CYC),
  parameter logic [39:0] DECAY_20_CYC = 40'(lerm_pkg::DECAY_20_CYC),
  parameter logic [39:0] DECAY_40_CYC = 40'(lerm_pkg::DECAY_40_CYC),
  parameter logic [39:0] DECAY_80_CYC = 40'(lerm_pkg::DECAY_80_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // error detector
  input wire logic xmit_err,
  // link reports
  output logic broken_link_evt,
  output logic degraded_link_evt,
  output logic irq
);

  // ==========================================================
  // bus slave
  lerm_pkg::lerm_dphase_t dp_r, dp_nxt;
  logic [15:0] addr_r;
  logic [31:0] hrdata_r;
  wire logic addr_ok = hsel && htrans[1] && hready;
  wire logic [15:0] haddr_lo = haddr[15:0];
  wire logic unused_size = |hsize;
  wire logic sel_ctrl = addr_r[15:2] == lerm_pkg::CTRL_OFS[15:2];
  wire logic sel_lim = addr_r[15:2] == lerm_pkg::LIMITS_OFS[15:2];
  wire logic sel_sts = addr_r[15:2] == lerm_pkg::IRQ_STS_OFS[15:2];
  wire logic sel_mask = addr_r[15:2] == lerm_pkg::IRQ_MASK_OFS[15:2];
  wire logic wr_phase = dp_r == lerm_pkg::DP_WR;
  wire logic wr_ctrl = wr_phase && sel_ctrl;
  wire logic wr_lim = wr_phase && sel_lim;
  wire logic wr_sts = wr_phase && sel_sts;
  wire logic wr_mask = wr_phase && sel_mask;

  always_comb
  begin
    dp_nxt = lerm_pkg::DP_IDLE;
    case (dp_r)
      lerm_pkg::DP_RD_WAIT: dp_nxt = lerm_pkg::DP_RD_DONE;
      lerm_pkg::DP_IDLE,
      lerm_pkg::DP_WR,
      lerm_pkg::DP_RD_DONE:
      begin
        if (addr_ok)
        begin
          dp_nxt = hwrite ? lerm_pkg::DP_WR : lerm_pkg::DP_RD_WAIT;
        end
      end
      default: dp_nxt = lerm_pkg::DP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dp_r <= lerm_pkg::DP_IDLE;
      addr_r <= 16'h0000;
    end
    else
    begin
      dp_r <= dp_nxt;
      if (addr_ok)
      begin
        addr_r <= haddr_lo;
      end
    end
  end

  // ==========================================================
  // registers
  lerm_pkg::lerm_ctrl_t ctrl_r, ctrl_nxt;
  lerm_pkg::lerm_limits_t lim_r;
  logic [1:0] sts_r;
  logic [1:0] mask_r;
  lerm_pkg::lerm_ctrl_t wr_ctrl_val;
  lerm_pkg::lerm_limits_t wr_lim_val;

  assign wr_ctrl_val = hwdata;
  assign wr_lim_val = hwdata;

  wire logic [7:0] decay_sel = ctrl_r.decay_step_select;
  wire logic [7:0] tally = ctrl_r.link_fault_tally;
  wire logic [7:0] peak = ctrl_r.peak_tally;
  wire logic [7:0] broken_lim = lim_r.broken_link_limit;
  wire logic [7:0] degraded_lim = lim_r.degraded_link_limit;

  // ==========================================================
  // decay timer
  logic [39:0] tick_cnt_r;
  logic [7:0] sel_seen_r;
  wire logic [39:0] decay_per =
    (decay_sel == lerm_pkg::DECAY_C01) ? DECAY_01_CYC :
    (decay_sel == lerm_pkg::DECAY_C02) ? DECAY_02_CYC :
    (decay_sel == lerm_pkg::DECAY_C04) ? DECAY_04_CYC :
    (decay_sel == lerm_pkg::DECAY_C08) ? DECAY_08_CYC :
    (decay_sel == lerm_pkg::DECAY_C10) ? DECAY_10_CYC :
    (decay_sel == lerm_pkg::DECAY_C20) ? DECAY_20_CYC :
    (decay_sel == lerm_pkg::DECAY_C40) ? DECAY_40_CYC :
    (decay_sel == lerm_pkg::DECAY_C80) ? DECAY_80_CYC :
    (decay_sel == lerm_pkg::DECAY_DEBUG) ? lerm_pkg::DECAY_DEBUG_CYC :
    40'h00_0000_0000;
  wire logic decay_on = decay_per != 40'h00_0000_0000;
  wire logic sel_changed = decay_sel != sel_seen_r;
  wire logic decay_tick = decay_on && !sel_changed &&
    (tick_cnt_r == decay_per - 40'h00_0000_0001);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tick_cnt_r <= 40'h00_0000_0000;
      sel_seen_r <= lerm_pkg::CTRL_RST[31:24];
    end
    else
    begin
      sel_seen_r <= decay_sel;
      if (!decay_on || sel_changed || decay_tick)
      begin
        tick_cnt_r <= 40'h00_0000_0000;
      end
      else
      begin
        tick_cnt_r <= tick_cnt_r + 40'h00_0000_0001;
      end
    end
  end

  // ==========================================================
  // tally ceiling
  wire logic [1:0] ovr_sel = ctrl_r.overshoot_limit_select;
  wire logic [8:0] ovr_add =
    (ovr_sel == 2'h0) ? lerm_pkg::OVERSHOOT_00 :
    (ovr_sel == 2'h1) ? lerm_pkg::OVERSHOOT_01 :
    lerm_pkg::OVERSHOOT_10;
  wire logic [8:0] ovr_sum = {1'b0, broken_lim} + ovr_add;
  wire logic no_cap = (ovr_sel == 2'h3) || (broken_lim == 8'h00);
  wire logic [8:0] tally_cap =
    (no_cap || ovr_sum > lerm_pkg::TALLY_MAX) ? lerm_pkg::TALLY_MAX :
    ovr_sum;

  // ==========================================================
  // tally and peak update
  wire logic can_inc = {1'b0, tally} < tally_cap;
  wire logic inc = xmit_err && can_inc;
  wire logic dec = decay_tick && (tally != 8'h00);
  wire logic [7:0] tally_hw =
    (inc && !dec) ? tally + 8'h01 :
    (dec && !inc) ? tally - 8'h01 :
    tally;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = wr_ctrl_val;
      ctrl_nxt.rsvd = 6'h00;
    end
    else
    begin
      ctrl_nxt.link_fault_tally = tally_hw;
      if (tally_hw > peak)
      begin
        ctrl_nxt.peak_tally = tally_hw;
      end
    end
  end

  // ==========================================================
  // limit reports
  wire logic hw_move = !wr_ctrl && (tally_hw != tally);
  wire logic hit_broken = hw_move && (broken_lim != 8'h00) &&
    (tally_hw == broken_lim);
  wire logic hit_degraded = hw_move && (degraded_lim != 8'h00) &&
    (tally_hw == degraded_lim);
  wire logic [1:0] sts_set = {hit_degraded, hit_broken};
  wire logic [1:0] sts_clr = wr_sts ? hwdata[1:0] : 2'h0;
  logic broken_evt_r;
  logic degraded_evt_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= lerm_pkg::CTRL_RST;
      lim_r <= lerm_pkg::LIMITS_RST;
      sts_r <= 2'h0;
      mask_r <= lerm_pkg::IRQ_MASK_RST;
      broken_evt_r <= 1'b0;
      degraded_evt_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      if (wr_lim)
      begin
        lim_r <= {wr_lim_val.broken_link_limit,
          wr_lim_val.degraded_link_limit, 16'h0000};
      end
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      if (wr_mask)
      begin
        mask_r <= hwdata[1:0];
      end
      broken_evt_r <= hit_broken;
      degraded_evt_r <= hit_degraded;
    end
  end

  // ==========================================================
  // read data
  wire logic [31:0] rd_mux =
    sel_ctrl ? ctrl_r :
    sel_lim ? lim_r :
    sel_sts ? {30'h0000_0000, sts_r} :
    sel_mask ? {30'h0000_0000, mask_r} :
    32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hrdata_r <= 32'h0000_0000;
    end
    else if (dp_r == lerm_pkg::DP_RD_WAIT)
    begin
      hrdata_r <= rd_mux;
    end
  end

  // ==========================================================
  // outputs
  // one wait state in the first read data phase cycle only
  assign hreadyout = (dp_r != lerm_pkg::DP_RD_WAIT);
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;
  assign broken_link_evt = broken_evt_r;
  assign degraded_link_evt = degraded_evt_r;
  assign irq = |(sts_r & mask_r);

endmodule // lerm_monitor

// file: lerm_err_source.sv
`timescale 1ns/1ps
module lerm_err_source (
  // clock
  input wire logic clk,
  // error pulses
  output logic xmit_err
);
  initial xmit_err = 1'b0;
  // ==========================================================
  // n one-cycle pulses, gap idle cycles between
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) xmit_err <= 1'b1;
      repeat (gap) @(posedge clk) xmit_err <= 1'b0;
    end
    @(posedge clk) xmit_err <= 1'b0;
  endtask
endmodule // lerm_err_source

// file: lerm_monitor_properties.sv
`timescale 1ns/1ps
module lerm_monitor_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // reports
  input wire logic broken_link_evt,
  input wire logic degraded_link_evt,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic take = hsel && htrans[1] && hready;
  // ==========================================================
  // properties
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write waited");
  a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_wait_only_read: assert property (!hreadyout |-> $past(take) && !$past(hwrite))
    else $error("stray wait state");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata moved");
  a_broken_single: assert property (broken_link_evt |=> !broken_link_evt)
    else $error("broken report repeated");
  a_degraded_single: assert property (degraded_link_evt |=> !degraded_link_evt)
    else $error("degraded report repeated");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq && hreadyout && !broken_link_evt)
    else $error("outputs not idle after reset");
endmodule // lerm_monitor_properties

bind lerm_monitor lerm_monitor_properties u_props (.clk(clk), .sys_rst(sys_rst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .broken_link_evt(broken_link_evt), .degraded_link_evt(degraded_link_evt),
  .irq(irq));

// file: lerm_monitor_bench.sv
`timescale 1ns/1ps
module lerm_monitor_bench;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, xmit_err;
  logic broken_link_evt, degraded_link_evt, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] c;
  logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
    8'h20, 8'h40, 8'h80, 8'hFF, 8'h03};
  int fail_count, checked, seed, n_brk, n_deg, n;
  longint p;
  assign hready = hreadyout;
  lerm_monitor #(.DECAY_01_CYC(40'd20), .DECAY_02_CYC(40'd30),
    .DECAY_04_CYC(40'd40), .DECAY_08_CYC(40'd50), .DECAY_10_CYC(40'd60))
  u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .xmit_err(xmit_err), .broken_link_evt(broken_link_evt),
    .degraded_link_evt(degraded_link_evt), .irq(irq));
  lerm_err_source u_src (.clk(clk), .xmit_err(xmit_err));
  // ==========================================================
  // expectations
  // shortened periods for the five fastest one-hot codes, true ones otherwise
  function automatic longint period(input logic [7:0] k);
    for (int i = 0; i < 5; i++)
      if (k == (8'h01 << i)) return 20 + 10 * i;
    if (k == 8'h20) return lerm_pkg::DECAY_20_CYC;
    if (k == 8'h40) return lerm_pkg::DECAY_40_CYC;
    if (k == 8'h80) return lerm_pkg::DECAY_80_CYC;
    return (k == 8'hFF) ? longint'(lerm_pkg::DECAY_DEBUG_CYC) : 0;
  endfunction
  function automatic logic [7:0] cap(input int s, input int lim);
    int a;
    a = (s == 0) ? 2 : (s == 1) ? 4 : (s == 2) ? 16 : 255;
    return (lim + a > 255) ? 8'hFF : 8'(lim + a);
  endfunction
  // ==========================================================
  // checking and bus
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1 && k < 16)
    begin
      @(posedge clk);
      k++;
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1 && k < 16)
    begin
      @(posedge clk);
      k++;
    end
    rd = hrdata;
    if (k >= 16)
    begin
      fail_count++;
      wrap_up;
    end
  endtask
  task rdchk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // ==========================================================
  // clock and event counters
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (broken_link_evt === 1'b1) n_brk <= n_brk + 1;
    if (degraded_link_evt === 1'b1) n_deg <= n_deg + 1;
  end
  // ==========================================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; fail_count = 0; checked = 0;
    seed = 32'hbb29; n_brk = 0; n_deg = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(lerm_pkg::CTRL_OFS, lerm_pkg::CTRL_RST);
    rdchk(lerm_pkg::LIMITS_OFS, lerm_pkg::LIMITS_RST);
    bus(1'b1, lerm_pkg::LIMITS_OFS, 32'h0804_FFFF);
    rdchk(lerm_pkg::LIMITS_OFS, 32'h0804_0000);
    rdchk(16'h1078, 32'h0000_0000);
    $display("test reset done");
    bus(1'b1, lerm_pkg::CTRL_OFS, 32'h0000_0000);
    bus(1'b1, lerm_pkg::IRQ_MASK_OFS, 32'h0000_0003);
    n = 1 + ($unsigned($random(seed)) % 3);
    u_src.send(n, $unsigned($random(seed)) % 3);
    rdchk(lerm_pkg::CTRL_OFS, {16'h0000, 8'(n), 8'(n)});
    u_src.send(4 - n, 0);
    rdchk(lerm_pkg::IRQ_STS_OFS, 32'h0000_0002);
    chk(32'(n_deg), 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, lerm_pkg::IRQ_STS_OFS, 32'h0000_0002);
    rdchk(lerm_pkg::IRQ_STS_OFS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    u_src.send(20, 0);
    rdchk(lerm_pkg::CTRL_OFS, 32'h0000_0A0A);
    chk({8'(n_brk), 8'(n_deg)}, 32'h0000_0101);
    bus(1'b1, lerm_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    rdchk(lerm_pkg::IRQ_STS_OFS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reports done");
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, lerm_pkg::CTRL_OFS, {14'h0000, 2'(s), 16'h0000});
      u_src.send(260, 0);
      rdchk(lerm_pkg::CTRL_OFS, {14'h0, 2'(s), cap(s, 8), cap(s, 8)});
    end
    $display("test overshoot done");
    foreach (codes[i])
    begin
      c = codes[i];
      p = period(c);
      // slow codes cannot tick inside the observation window
      if (p > 1000) p = 0;
      bus(1'b1, lerm_pkg::CTRL_OFS, {c, 16'h000C, 8'h09});
      repeat ((p == 0) ? 100 : p * 2 + p / 2) @(posedge clk);
      rdchk(lerm_pkg::CTRL_OFS, {c, 16'h000C, (p == 0) ? 8'h09 : 8'h07});
    end
    bus(1'b1, lerm_pkg::CTRL_OFS, 32'hFF00_0101);
    repeat (200) @(posedge clk);
    rdchk(lerm_pkg::CTRL_OFS, 32'hFF00_0100);
    $display("test decay done");
    wrap_up;
  end
endmodule // lerm_monitor_bench
